// File: tbisc_regs.sv
// Purpose: circular buffer index and serial port control/status registers on avalon-mm
// Assumes: serial core strobes come from logic on core_clk, so they are not synchronised
// Notes:   every access answers on the second edge with ce high; unmapped reads return zero
`timescale 1ns/1ns
`include "tbisc_defs.svh"

// How it works
// - five-bit index in bits 5..1 points at the next free of 32 entries
// - entry address is index framed by ones at bits 7,6 and zero at bit 0
// - unused index bits 0, 6, 7 are undefined; this design returns zero
// - reset clears the read/write index so it selects the lowest entry
// - soft reset bit set holds the serial port reset; clear it to run
// - control bits: rx full 7, tx empty 6, parity 5, framing 4, enables 3,2, reset 0
// - tx empty sets on reset, soft reset and shift-out; reads zero when full
// - receive interrupt requested when enabled and receive buffer becomes full
module tbisc_regs (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // avalon-mm slave
  input  wire logic [15:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // buffer side
  input  wire logic        buf_advance,
  output logic      [7:0]  buf_entry_addr,
  // serial core side
  input  wire logic        rx_full_set,
  input  wire logic        rx_parity_in,
  input  wire logic        rx_frame_err_set,
  input  wire logic        tx_loaded,
  input  wire logic        tx_shifted_out,
  output logic             serial_soft_reset,
  // interrupts
  output logic             rx_irq_req,
  output logic             tx_irq_req,
  output logic             irq
);

  // decode a byte address into a register select; read and write paths share it
  function automatic tbisc_pkg::tbisc_sel_e reg_decode(input logic [15:0] a);
    logic [13:0] idx;
    idx = a[15:2];
    unique case (idx)
      `TBISC_IDX_INDEX:   reg_decode = tbisc_pkg::sel_index;
      `TBISC_SCTL_INDEX:  reg_decode = tbisc_pkg::sel_sctl;
      `TBISC_ISTAT_INDEX: reg_decode = tbisc_pkg::sel_istat;
      `TBISC_IMASK_INDEX: reg_decode = tbisc_pkg::sel_imask;
      default:            reg_decode = tbisc_pkg::sel_none;
    endcase
  endfunction

  // ---------------------------------------------------------------- bus
  logic                  ack_r;
  logic                  ack_nxt;
  logic [31:0]           readdata_r;
  logic [31:0]           readdata_nxt;
  tbisc_pkg::tbisc_sel_e sel;
  logic                  req;
  logic                  wr_commit;
  logic                  wr_lane0;
  logic [31:0]           rd_mux;

  // state registers referenced by the read mux, with their next values and event strobes
  logic [4:0]            idx_r;
  logic [4:0]            idx_nxt;
  logic                  rxf_r;
  logic                  txe_r;
  logic                  par_r;
  logic                  fe_r;
  logic                  rxie_r;
  logic                  txie_r;
  logic                  srst_r;
  logic                  rxf_nxt;
  logic                  txe_nxt;
  logic                  par_nxt;
  logic                  fe_nxt;
  logic                  rxie_nxt;
  logic                  txie_nxt;
  logic                  srst_nxt;
  logic [`TBISC_IRQ_W-1:0] istat;
  logic [`TBISC_IRQ_W-1:0] imask_r;
  logic [`TBISC_IRQ_W-1:0] imask_nxt;
  logic [`TBISC_IRQ_W-1:0] evt;
  logic [`TBISC_IRQ_W-1:0] istat_clr;
  logic                  wrap_evt;
  // serial control reset picture, split per bit so each flop gets a one-bit constant
  localparam logic [7:0] SCTL_RST = `TBISC_SCTL_RST;

  assign req         = read | write;
  assign sel         = reg_decode(address);
  // a frozen clock enable keeps the master waiting, so no write is lost
  assign waitrequest = req & (~ack_r | ~ce);
  assign wr_commit   = write & ack_r & ce;
  assign wr_lane0    = wr_commit & byteenable[0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (sel)
      tbisc_pkg::sel_index: begin
        rd_mux[`TBISC_IDX_MSB:`TBISC_IDX_LSB] = idx_r;
      end
      tbisc_pkg::sel_sctl: begin
        rd_mux[`TBISC_SCTL_RXF]  = rxf_r;
        rd_mux[`TBISC_SCTL_TXE]  = txe_r;
        rd_mux[`TBISC_SCTL_PAR]  = par_r;
        rd_mux[`TBISC_SCTL_FE]   = fe_r;
        rd_mux[`TBISC_SCTL_RXIE] = rxie_r;
        rd_mux[`TBISC_SCTL_TXIE] = txie_r;
        rd_mux[`TBISC_SCTL_SRST] = srst_r;
      end
      tbisc_pkg::sel_istat: begin
        rd_mux[`TBISC_IRQ_W-1:0] = istat;
      end
      tbisc_pkg::sel_imask: begin
        rd_mux[`TBISC_IRQ_W-1:0] = imask_r;
      end
      tbisc_pkg::sel_none: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    ack_nxt      = 1'b0;
    readdata_nxt = readdata_r;
    if (req && !ack_r) begin
      ack_nxt = 1'b1;
      // read data is caught a cycle early and stands through the answering edge
      if (read) begin
        readdata_nxt = rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r      <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else if (ce) begin
      ack_r      <= ack_nxt;
      readdata_r <= readdata_nxt;
    end
  end

  assign readdata = readdata_r;

  // ---------------------------------------------------------------- buffer index
  always_comb begin
    idx_nxt  = idx_r;
    wrap_evt = 1'b0;
    // a software write wins over a simultaneous advance
    if (wr_lane0 && sel == tbisc_pkg::sel_index) begin
      idx_nxt = writedata[`TBISC_IDX_MSB:`TBISC_IDX_LSB];
    end else if (buf_advance) begin
      if (idx_r == `TBISC_IDX_LAST) begin
        idx_nxt  = `TBISC_IDX_RST;
        wrap_evt = 1'b1;
      end else begin
        idx_nxt = idx_r + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idx_r <= `TBISC_IDX_RST;
    end else if (ce) begin
      idx_r <= idx_nxt;
    end
  end

  assign buf_entry_addr = {`TBISC_ENTRY_HI, idx_r, `TBISC_ENTRY_LO};

  // ---------------------------------------------------------------- serial control
  logic sctl_wr;

  assign sctl_wr = wr_lane0 && sel == tbisc_pkg::sel_sctl;

  always_comb begin
    rxie_nxt = rxie_r;
    txie_nxt = txie_r;
    srst_nxt = srst_r;
    rxf_nxt  = rxf_r;
    par_nxt  = par_r;
    fe_nxt   = fe_r;
    txe_nxt  = txe_r;
    if (sctl_wr) begin
      rxie_nxt = writedata[`TBISC_SCTL_RXIE];
      txie_nxt = writedata[`TBISC_SCTL_TXIE];
      srst_nxt = writedata[`TBISC_SCTL_SRST];
    end
    if (srst_r) begin
      // port held in reset: status returns to its reset picture
      rxf_nxt = 1'b0;
      par_nxt = 1'b0;
      fe_nxt  = 1'b0;
      txe_nxt = 1'b1;
    end else begin
      // clearable flags are cleared by writing zero; a new event wins
      if (rx_full_set) begin
        rxf_nxt = 1'b1;
        par_nxt = rx_parity_in;
      end else if (sctl_wr && !writedata[`TBISC_SCTL_RXF]) begin
        rxf_nxt = 1'b0;
      end
      if (rx_frame_err_set) begin
        fe_nxt = 1'b1;
      end else if (sctl_wr && !writedata[`TBISC_SCTL_FE]) begin
        fe_nxt = 1'b0;
      end
      if (tx_shifted_out) begin
        txe_nxt = 1'b1;
      end else if (tx_loaded) begin
        txe_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxf_r  <= SCTL_RST[`TBISC_SCTL_RXF];
      txe_r  <= SCTL_RST[`TBISC_SCTL_TXE];
      par_r  <= SCTL_RST[`TBISC_SCTL_PAR];
      fe_r   <= SCTL_RST[`TBISC_SCTL_FE];
      rxie_r <= 1'b0;
      txie_r <= 1'b0;
      srst_r <= 1'b0;
    end else if (ce) begin
      rxf_r  <= rxf_nxt;
      txe_r  <= txe_nxt;
      par_r  <= par_nxt;
      fe_r   <= fe_nxt;
      rxie_r <= rxie_nxt;
      txie_r <= txie_nxt;
      srst_r <= srst_nxt;
    end
  end

  assign serial_soft_reset = srst_r;
  assign rx_irq_req        = rxie_r & rxf_r;
  assign tx_irq_req        = txie_r & txe_r;

  // ---------------------------------------------------------------- interrupts
  always_comb begin
    evt                  = '0;
    evt[`TBISC_IRQ_RX]   = rx_full_set & rxie_r & ~srst_r;
    evt[`TBISC_IRQ_TX]   = txe_nxt & ~txe_r & txie_r;
    evt[`TBISC_IRQ_FE]   = rx_frame_err_set & ~srst_r;
    evt[`TBISC_IRQ_WRAP] = wrap_evt;
    istat_clr            = '0;
    if (wr_lane0 && sel == tbisc_pkg::sel_istat) begin
      istat_clr = writedata[`TBISC_IRQ_W-1:0];
    end
    imask_nxt = imask_r;
    if (wr_lane0 && sel == tbisc_pkg::sel_imask) begin
      imask_nxt = writedata[`TBISC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      imask_r <= `TBISC_IRQ_RST;
    end else if (ce) begin
      imask_r <= imask_nxt;
    end
  end

  tbisc_sticky #(
    .W (`TBISC_IRQ_W)
  ) u_istat (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .set      (evt),
    .clr      (istat_clr),
    .q        (istat)
  );

  // level output: stays high until every unmasked sticky bit is cleared
  assign irq = |(istat & imask_r);

endmodule

// File: tbisc_defs.svh
// Purpose: offsets, field positions, reset values for the buffer index and serial control block
// Assumes: avalon byte address = 4 * register index
// Notes:   definitions only
`ifndef TBISC_DEFS_SVH
`define TBISC_DEFS_SVH

// register indices (byte address is four times these)
`define TBISC_IDX_INDEX    14'h1043
`define TBISC_SCTL_INDEX   14'h1045
`define TBISC_ISTAT_INDEX  14'h1046
`define TBISC_IMASK_INDEX  14'h1047

// buffer index register
`define TBISC_IDX_LSB      1
`define TBISC_IDX_MSB      5
`define TBISC_IDX_RST      5'h00
`define TBISC_IDX_LAST     5'h1f
`define TBISC_ENTRY_HI     2'h3
`define TBISC_ENTRY_LO     1'h0

// serial control/status register
`define TBISC_SCTL_RXF     7
`define TBISC_SCTL_TXE     6
`define TBISC_SCTL_PAR     5
`define TBISC_SCTL_FE      4
`define TBISC_SCTL_RXIE    3
`define TBISC_SCTL_TXIE    2
`define TBISC_SCTL_SRST    0
`define TBISC_SCTL_RST     8'h40

// interrupt status / mask layout
`define TBISC_IRQ_W        4
`define TBISC_IRQ_RX       0
`define TBISC_IRQ_TX       1
`define TBISC_IRQ_FE       2
`define TBISC_IRQ_WRAP     3
`define TBISC_IRQ_RST      4'h0

`endif

// File: tbisc_pkg.sv
// Purpose: shared types for the buffer index and serial control block
// Assumes: nothing
// Notes:   register selection after address decode
package tbisc_pkg;

  typedef enum logic [2:0] {
    sel_none,
    sel_index,
    sel_sctl,
    sel_istat,
    sel_imask
  } tbisc_sel_e;

endpackage

// File: tbisc_sticky.sv
// Purpose: sticky event flags with write-one-to-clear
// Assumes: set and clear are single-cycle strobes on core_clk
// Notes:   a set in the same cycle as a clear wins
`timescale 1ns/1ns
module tbisc_sticky #(
  parameter int W = 4
) (
  // clock, reset and enable
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // events and clears
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flags
  output logic      [W-1:0] q
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    // set wins so an event arriving during the clear is not lost
    q_nxt = (q_r & ~clr) | set;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// File: tbisc_regs_sva.sv
// Purpose: port assertions for tbisc_regs
// Assumes: ce held high while a request is pending
// Notes:   bound after the module
`timescale 1ns/1ns
module tbisc_regs_chk (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // bus
  input wire logic       ce,
  input wire logic       read,
  input wire logic       write,
  input wire logic       waitrequest,
  // events
  input wire logic       buf_advance,
  input wire logic       rx_full_set,
  input wire logic       rx_frame_err_set,
  input wire logic       tx_shifted_out,
  // outputs
  input wire logic [7:0] buf_entry_addr,
  input wire logic       serial_soft_reset,
  input wire logic       rx_irq_req,
  input wire logic       tx_irq_req,
  input wire logic       irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // a bus write to the index register with the low byte lane wins over an advance in the same cycle
  wire logic wr_done = write && !waitrequest;
  a_entry_frame: assert property (buf_entry_addr[7:6] == 2'h3 && !buf_entry_addr[0])
    else $error("entry address frame broken");
  a_index_step: assert property (buf_advance && ce && !wr_done |=>
    buf_entry_addr[5:1] == $past(buf_entry_addr[5:1]) + 5'h1) else $error("index step wrong");
  a_index_hold: assert property (!buf_advance && !wr_done |=> $stable(buf_entry_addr))
    else $error("index moved without cause");
  a_req_waits: assert property ($rose(read || write) |-> waitrequest)
    else $error("request answered at once");
  a_req_answer: assert property ($rose(read || write) && ce |=> !waitrequest || !ce)
    else $error("request not answered in the second cycle");
  a_srst_rx_quiet: assert property (serial_soft_reset && $past(serial_soft_reset) |-> !rx_irq_req)
    else $error("receive request under soft reset");
  a_rx_irq_cause: assert property ($rose(rx_irq_req) |-> $past(rx_full_set || write))
    else $error("receive request without cause");
  a_tx_irq_cause: assert property ($rose(tx_irq_req) |->
    $past(tx_shifted_out || write || serial_soft_reset)) else $error("transmit request without cause");
  a_irq_cause: assert property ($rose(irq) |-> $past(rx_full_set || rx_frame_err_set
    || tx_shifted_out || buf_advance || write || serial_soft_reset)) else $error("irq without cause");
endmodule

bind tbisc_regs tbisc_regs_chk u_chk (.core_clk(core_clk), .nrst(nrst), .ce(ce), .read(read),
  .write(write), .waitrequest(waitrequest), .buf_advance(buf_advance),
  .rx_full_set(rx_full_set), .rx_frame_err_set(rx_frame_err_set),
  .tx_shifted_out(tx_shifted_out), .buf_entry_addr(buf_entry_addr),
  .serial_soft_reset(serial_soft_reset), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req),
  .irq(irq));

// File: tbisc_regs_bench.sv
// Purpose: register and event tests for tbisc_regs
// Assumes: ce and byteenable held on except in their own scenarios
// Notes:   bus answers are sampled at the rising edge, before that edge's updates land
`timescale 1ns/1ns
`include "tbisc_defs.svh"
module tbisc_regs_bench;
  localparam logic [15:0] IDX = {`TBISC_IDX_INDEX, 2'h0};
  localparam logic [15:0] SCTL = {`TBISC_SCTL_INDEX, 2'h0};
  localparam logic [15:0] IST = {`TBISC_ISTAT_INDEX, 2'h0};
  localparam logic [15:0] IMSK = {`TBISC_IMASK_INDEX, 2'h0};
  logic        core_clk, nrst, read, write, ce, rx_parity_in;
  logic [3:0]  be;
  logic        waitrequest, serial_soft_reset, rx_irq_req, tx_irq_req, irq;
  logic [15:0] address;
  logic [31:0] writedata, readdata, rs;
  logic [7:0]  buf_entry_addr;
  logic [4:0]  ev;
  int          err_total, checks;

  tbisc_regs u_tbisc_regs (.core_clk(core_clk), .nrst(nrst), .ce(ce), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
    .waitrequest(waitrequest), .buf_advance(ev[4]), .buf_entry_addr(buf_entry_addr),
    .rx_full_set(ev[0]), .rx_parity_in(rx_parity_in), .rx_frame_err_set(ev[1]),
    .tx_loaded(ev[2]), .tx_shifted_out(ev[3]), .serial_soft_reset(serial_soft_reset),
    .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {24'h0, d};
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    rs = readdata;
    read <= 1'b0;
    write <= 1'b0;
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rs[7:0] & m, e);
  endtask
  task pulse(input logic [4:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 5'h00;
    #1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #20000;
    err_total++;
    end_sim;
  end

  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 16'h0000;
    writedata = 32'h0;
    ev = 5'h00;
    rx_parity_in = 1'b1;
    ce = 1'b1;
    be = 4'h1;
    err_total = 0;
    checks = 0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    rd(IDX, 8'h3e, 8'h00);
    rd(SCTL, 8'hff, 8'h40);
    rd(IST, 8'h0f, 8'h00);
    rd(IMSK, 8'h0f, 8'h00);
    rd(16'h4000, 8'hff, 8'h00);
    chk(buf_entry_addr, 8'hc0);
    acc(1'b1, IDX, 8'hff);
    rd(IDX, 8'h3e, 8'h3e);
    chk(buf_entry_addr, 8'hfe);
    // a write without the low byte lane is answered but stores nothing
    @(posedge core_clk);
    be <= 4'h0;
    acc(1'b1, IDX, 8'h00);
    rd(IDX, 8'h3e, 8'h3e);
    @(posedge core_clk);
    be <= 4'h1;
    acc(1'b1, IMSK, 8'h0f);
    for (int i = 0; i < 32; i++) begin
      pulse(5'h10);
      chk(buf_entry_addr, 8'hc0 + 8'(2 * i));
    end
    chk(8'(irq), 8'h01);
    rd(IST, 8'h08, 8'h08);
    acc(1'b1, IST, 8'h0f);
    chk(8'(irq), 8'h00);
    acc(1'b1, SCTL, 8'h08);
    pulse(5'h01);
    rd(SCTL, 8'hff, 8'he8);
    chk(8'(rx_irq_req), 8'h01);
    chk(8'(irq), 8'h01);
    acc(1'b1, IST, 8'h0f);
    acc(1'b1, SCTL, 8'h08);
    rd(SCTL, 8'hff, 8'h68);
    chk(8'(rx_irq_req), 8'h00);
    pulse(5'h02);
    rd(SCTL, 8'h10, 8'h10);
    acc(1'b1, IST, 8'h0f);
    acc(1'b1, SCTL, 8'h04);
    pulse(5'h04);
    rd(SCTL, 8'h50, 8'h00);
    chk(8'(tx_irq_req), 8'h00);
    pulse(5'h08);
    chk(8'(tx_irq_req), 8'h01);
    rd(IST, 8'h0f, 8'h02);
    pulse(5'h04);
    acc(1'b1, SCTL, 8'h0d);
    chk(8'(serial_soft_reset), 8'h01);
    pulse(5'h01);
    rd(SCTL, 8'hff, 8'h4d);
    chk(8'(rx_irq_req), 8'h00);
    acc(1'b1, SCTL, 8'h00);
    chk(8'(serial_soft_reset), 8'h00);
    // a low clock enable freezes the index, so the advance is lost
    @(posedge core_clk);
    ce <= 1'b0;
    pulse(5'h10);
    chk(buf_entry_addr, 8'hfe);
    @(posedge core_clk);
    ce <= 1'b1;
    pulse(5'h10);
    chk(buf_entry_addr, 8'hc0);
    chk(8'(irq), 8'h01);
    end_sim;
  end
endmodule
